/* File: shared/clkout_pkg.sv */
// Constants and types for the host output clock divider
package clkout_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int XTAL_HZ = 30_000_000;
    localparam int RATE_UNIT = 10_000_000;
    // Crystal edges per system clock, as a step over a modulus
    localparam logic [3:0] EDGE_STEP = 4'(2 * XTAL_HZ / RATE_UNIT);
    localparam logic [3:0] EDGE_MOD = 4'(CLK_HZ / RATE_UNIT);

    localparam logic [5:0] REG_CLK_CTRL_IDX = 6'h0A;
    localparam logic [5:0] REG_STATUS_IDX = 6'h0B;
    localparam logic [7:0] CLK_CTRL_RST = 8'h06;
    localparam int FREQ_SEL_LSB = 0;
    localparam int LF_SLEEP_BIT = 3;
    localparam int TAIL_SEL_LSB = 4;
    localparam logic [2:0] SEL_LF = 3'h7;

    localparam int STAT_XTAL_BIT = 0;
    localparam int STAT_SRC_XTAL_BIT = 1;
    localparam int STAT_SRC_LF_BIT = 2;
    localparam int STAT_TAIL_BIT = 3;
    localparam int STAT_SLEEP_BIT = 4;
    localparam int STAT_PIN_BIT = 5;

    typedef logic [5:0] div_cnt_t;
    // Output period and high phase, in crystal half periods
    localparam div_cnt_t DIV_PERIOD [8] = '{6'h02, 6'h04, 6'h06, 6'h0F,
                                            6'h14, 6'h1E, 6'h3C, 6'h02};
    localparam div_cnt_t DIV_HIGH [8] = '{6'h01, 6'h02, 6'h03, 6'h07,
                                          6'h0A, 6'h0F, 6'h1E, 6'h01};
    localparam logic [9:0] TAIL_CNT [4] = '{10'h000, 10'h080, 10'h100, 10'h200};

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_TAIL = 4'h2,
        ST_LF = 4'h4,
        ST_OFF = 4'h8
    } slp_state_t;

    typedef enum logic [2:0] {
        SRC_OFF = 3'h1,
        SRC_XTAL = 3'h2,
        SRC_LF = 3'h4
    } src_t;

endpackage

/* File: shared/clk_div_if.sv */
// Carrier between the output clock controller and the crystal divider
`timescale 1ns/100ps
interface clk_div_if;
    logic tick;
    logic run;
    logic [2:0] sel;
    logic out;
    logic busy;
    logic wrap;

    modport ctrl (output tick, output run, output sel, input out, input busy, input wrap);
    modport div (input tick, input run, input sel, output out, output busy, output wrap);
endinterface

/* File: hw/xtal_divider.sv */
// Integer divider of crystal half periods, retimed at period boundaries
`timescale 1ns/100ps
module xtal_divider
    import clkout_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    clk_div_if.div bus
);

    div_cnt_t cnt;
    logic [2:0] cur_sel;

    ////////////////////////////////////////////////////////////////////////
    // Select is taken only at a period start, so no phase is cut short
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt <= '0;
            cur_sel <= CLK_CTRL_RST[2:0];
            bus.out <= 1'b0;
            bus.busy <= 1'b0;
            bus.wrap <= 1'b0;
        end else begin
            bus.wrap <= 1'b0;
            if (bus.tick) begin
                if (!bus.busy || cnt == DIV_PERIOD[cur_sel]) begin
                    bus.wrap <= bus.busy;
                    if (bus.run) begin
                        cur_sel <= bus.sel;
                        cnt <= 6'h01;
                        bus.out <= 1'b1;
                        bus.busy <= 1'b1;
                    end else begin
                        bus.out <= 1'b0;
                        bus.busy <= 1'b0;
                    end
                end else begin
                    if (cnt == DIV_HIGH[cur_sel]) begin
                        bus.out <= 1'b0;
                    end
                    cnt <= cnt + 6'h01;
                end
            end
        end
    end

endmodule

/* File: hw/mcu_output_clock_divider.sv */
// Output clock generator for the host microcontroller
`timescale 1ns/100ps
module mcu_output_clock_divider
    import clkout_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_sleep_cmd,
    input wire logic i_irq_pending,
    input wire logic i_lf_xtal_sel,
    input wire logic i_lf_rc_clk,
    input wire logic i_lf_xtal_clk,
    output logic o_clock_output_pin,
    output logic o_xtal_en
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] clk_ctrl;
    logic [2:0] freq_sel;
    logic lf_in_sleep;
    logic [1:0] tail_sel;

    logic [1:0] lf_meta;
    logic [1:0] lf_sync;
    logic lf_level;
    logic lf_prev;
    logic lf_rise;

    logic [3:0] edge_acc;
    logic [3:0] next_edge_acc;
    logic edge_tick;

    slp_state_t state;
    slp_state_t next_state;
    src_t cur_src;
    src_t want_src;
    logic sleep_req;
    logic period_end;
    logic [9:0] tail_left;

    logic bus_req;
    logic wr_en;
    logic [5:0] word_idx;
    logic [31:0] rd_word;

    clk_div_if div_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Control register fields

    assign freq_sel = clk_ctrl[FREQ_SEL_LSB +: 3];
    assign lf_in_sleep = clk_ctrl[LF_SLEEP_BIT];
    assign tail_sel = clk_ctrl[TAIL_SEL_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Low-frequency source synchronisers

    wire logic [1:0] lf_pins = {i_lf_xtal_clk, i_lf_rc_clk};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_lf_sync
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    lf_meta[i] <= 1'b0;
                    lf_sync[i] <= 1'b0;
                end else begin
                    lf_meta[i] <= lf_pins[i];
                    lf_sync[i] <= lf_meta[i];
                end
            end
        end
    endgenerate

    // External crystal replaces the RC oscillator when selected
    assign lf_level = i_lf_xtal_sel ? lf_sync[1] : lf_sync[0];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lf_prev <= 1'b0;
        end else begin
            lf_prev <= lf_level;
        end
    end

    assign lf_rise = lf_level && !lf_prev;

    ////////////////////////////////////////////////////////////////////////
    // Crystal half-period enable, averaged over the system clock

    always_comb begin
        next_edge_acc = edge_acc + EDGE_STEP;
        edge_tick = 1'b0;
        if (next_edge_acc >= EDGE_MOD) begin
            next_edge_acc = next_edge_acc - EDGE_MOD;
            edge_tick = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            edge_acc <= '0;
        end else if (o_xtal_en) begin
            edge_acc <= next_edge_acc;
        end
    end

    // No crystal edges reach the divider while the crystal is off
    assign div_bus.tick = edge_tick && o_xtal_en;
    assign div_bus.sel = freq_sel;
    assign div_bus.run = (want_src == SRC_XTAL) && (cur_src == SRC_XTAL);

    xtal_divider u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(div_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sleep sequencing

    // Pending interrupt holds off the commanded sleep
    assign sleep_req = i_sleep_cmd && !i_irq_pending;

    assign period_end = ((cur_src == SRC_XTAL) && div_bus.wrap)
                     || ((cur_src == SRC_LF) && lf_rise);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (sleep_req) begin
                    if (lf_in_sleep) begin
                        next_state = ST_LF;
                    end else if (tail_sel == 2'h0) begin
                        next_state = ST_OFF;
                    end else begin
                        next_state = ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                if (!sleep_req) begin
                    next_state = ST_RUN;
                end else if (period_end && tail_left == 10'h001) begin
                    next_state = ST_OFF;
                end
            end
            ST_LF: begin
                if (!sleep_req) begin
                    next_state = ST_RUN;
                end
            end
            ST_OFF: begin
                if (!sleep_req) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Tail counter starts at sleep entry
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tail_left <= '0;
        end else if (state == ST_RUN) begin
            tail_left <= TAIL_CNT[tail_sel];
        end else if (state == ST_TAIL && period_end && tail_left != 10'h000) begin
            tail_left <= tail_left - 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection, changed only while the output is low

    always_comb begin
        unique case (state)
            ST_RUN, ST_TAIL: begin
                want_src = (freq_sel == SEL_LF) ? SRC_LF : SRC_XTAL;
            end
            ST_LF: begin
                want_src = SRC_LF;
            end
            ST_OFF: begin
                want_src = SRC_OFF;
            end
            default: begin
                want_src = SRC_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cur_src <= SRC_XTAL;
        end else if (cur_src != want_src) begin
            unique case (cur_src)
                SRC_XTAL: begin
                    if (!div_bus.busy) begin
                        cur_src <= SRC_OFF;
                    end
                end
                SRC_LF: begin
                    if (!lf_level) begin
                        cur_src <= SRC_OFF;
                    end
                end
                SRC_OFF: begin
                    if (want_src == SRC_XTAL && !div_bus.busy) begin
                        cur_src <= SRC_XTAL;
                    end else if (want_src == SRC_LF && !lf_level) begin
                        cur_src <= SRC_LF;
                    end
                end
                default: begin
                    cur_src <= SRC_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_clock_output_pin <= 1'b0;
        end else begin
            unique case (cur_src)
                SRC_XTAL: o_clock_output_pin <= div_bus.out;
                SRC_LF: o_clock_output_pin <= lf_level;
                SRC_OFF: o_clock_output_pin <= 1'b0;
                default: o_clock_output_pin <= 1'b0;
            endcase
        end
    end

    // Crystal stops once asleep and the divider has finished its period
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_xtal_en <= 1'b1;
        end else begin
            o_xtal_en <= !((state == ST_LF || state == ST_OFF)
                           && !div_bus.busy && cur_src != SRC_XTAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign word_idx = i_wb_adr[7:2];
    assign wr_en = bus_req && i_wb_we && i_wb_sel[0] && word_idx == REG_CLK_CTRL_IDX;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= bus_req;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            clk_ctrl <= CLK_CTRL_RST;
        end else if (wr_en) begin
            clk_ctrl <= {2'h0, i_wb_dat[5:0]};
        end
    end

    always_comb begin
        rd_word = '0;
        if (word_idx == REG_CLK_CTRL_IDX) begin
            rd_word[7:0] = clk_ctrl;
        end else if (word_idx == REG_STATUS_IDX) begin
            rd_word[STAT_XTAL_BIT] = o_xtal_en;
            rd_word[STAT_SRC_XTAL_BIT] = (cur_src == SRC_XTAL);
            rd_word[STAT_SRC_LF_BIT] = (cur_src == SRC_LF);
            rd_word[STAT_TAIL_BIT] = (state == ST_TAIL);
            rd_word[STAT_SLEEP_BIT] = (state == ST_LF || state == ST_OFF);
            rd_word[STAT_PIN_BIT] = o_clock_output_pin;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wb_dat <= '0;
        end else if (bus_req && !i_wb_we) begin
            o_wb_dat <= rd_word;
        end
    end

endmodule

/* File: tb/mcu_output_clock_divider_asserts.sv */
// Concurrent checks on the output clock divider ports
`timescale 1ns/100ps
module clkout_checker
    import clkout_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_sleep_cmd,
    input wire logic i_irq_pending,
    input wire logic i_lf_xtal_sel,
    input wire logic i_lf_rc_clk,
    input wire logic i_lf_xtal_clk,
    input wire logic o_clock_output_pin,
    input wire logic o_xtal_en
);
    logic [5:0] ctrl;

    // Shadow of the control register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl <= CLK_CTRL_RST[5:0];
        end else if (i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0]
                     && i_wb_adr[7:2] == REG_CLK_CTRL_IDX) begin
            ctrl <= i_wb_dat[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence req_s;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence pulse_s;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    ack_pulse_a: assert property (req_s |=> pulse_s)
        else $error("ack not a single pulse one cycle after request");
    ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    rd_ctrl_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr[7:2] == REG_CLK_CTRL_IDX
        |-> o_wb_dat == {26'h0, ctrl})
        else $error("control read data wrong");
    rd_unmap_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr[7:2] != REG_CLK_CTRL_IDX
        && i_wb_adr[7:2] != REG_STATUS_IDX |-> o_wb_dat == 32'h0)
        else $error("unmapped read not zero");
    awake_xtal_a: assert property (!i_sleep_cmd [*8] |-> o_xtal_en)
        else $error("crystal off while awake");
    irq_xtal_a: assert property (i_irq_pending [*8] |-> o_xtal_en)
        else $error("crystal off with interrupt pending");
    xtal_stop_a: assert property ($fell(o_xtal_en)
        |-> $past(i_sleep_cmd && !i_irq_pending, 2))
        else $error("crystal stopped without effective sleep");
    off_pin_a: assert property (!o_xtal_en && i_sleep_cmd && $past(i_sleep_cmd)
        && !ctrl[LF_SLEEP_BIT] |-> !o_clock_output_pin)
        else $error("pin active with output disabled in sleep");
endmodule

bind mcu_output_clock_divider clkout_checker u_chk (.*);

/* File: tb/host_clock_sink.sv */
// Host side model counting rising edges of the supplied clock
`timescale 1ns/100ps
module host_clock_sink (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_pin,
    output int o_edges
);
    logic prev = 1'b0;

    always_ff @(posedge i_clk) begin
        prev <= i_pin;
        if (i_clr) begin
            o_edges <= 0;
        end else if (i_pin && !prev) begin
            o_edges <= o_edges + 1;
        end
    end
endmodule

/* File: tb/tb_mcu_output_clock_divider.sv */
// Self-checking bench for the host output clock divider
`timescale 1ns/100ps
module tb_mcu_output_clock_divider;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slp = 0, irq = 0, lfs = 0;
    logic lf_rc = 0, lf_x = 0, clr = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, pin, xen;
    int edges, n_mismatch = 0, tests_run = 0, t0, span;
    localparam int EXP30 [7] = '{100, 200, 300, 750, 1000, 1500, 3000};
    localparam int TAILS [4] = '{0, 128, 256, 512};

    mcu_output_clock_divider DUT (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_sleep_cmd(slp), .i_irq_pending(irq),
        .i_lf_xtal_sel(lfs), .i_lf_rc_clk(lf_rc), .i_lf_xtal_clk(lf_x),
        .o_clock_output_pin(pin), .o_xtal_en(xen));
    host_clock_sink HOST (.i_clk(clk), .i_clr(clr), .i_pin(pin), .o_edges(edges));

    initial begin forever #5 clk = ~clk; end
    initial begin forever #15259 lf_rc = ~lf_rc; end
    initial begin #7001; forever #15259 lf_x = ~lf_x; end

    ////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_near(input int got, input int exp, input int tol);
        tests_run++;
        if (got - exp > tol || exp - got > tol) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    task period(input int n);
        @(posedge pin);
        t0 = int'($time);
        repeat (n) @(posedge pin);
        span = (int'($time) - t0) / 10;
    endtask

    task sleep_tail(input logic [1:0] t);
        wb(1, 8'h28, {26'h0, t, 4'h0});
        repeat (50) @(posedge clk);
        clr <= 1;
        slp <= 1;
        @(posedge clk);
        clr <= 0;
        while (xen !== 1'b0) @(posedge clk);
        chk_near(edges, TAILS[t], 1);
        repeat (200) @(posedge clk);
        chk({31'h0, pin}, 32'h0);
        slp <= 0;
        repeat (300) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        final_report;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        wb(0, 8'h28, 0);
        chk(q, 32'h06);
        wb(0, 8'h2C, 0);
        chk(q & 32'h1, 32'h1);
        wb(0, 8'h00, 0);
        chk(q, 32'h0);
        wb(1, 8'h28, 32'hFF);
        wb(0, 8'h28, 0);
        chk(q, 32'h3F);
        for (int i = 0; i < 7; i++) begin
            wb(1, 8'h28, i);
            repeat (300) @(posedge clk);
            period(30);
            chk_near(span, EXP30[i], 2);
        end
        wb(1, 8'h28, 32'h07);
        period(3);
        chk_near(span, 9155, 3);
        wb(1, 8'h28, 32'h08);
        lfs <= 1;
        repeat (100) @(posedge clk);
        slp <= 1;
        // Let the last crystal period finish before timing the slow clock
        repeat (100) @(posedge clk);
        period(3);
        chk_near(span, 9155, 3);
        chk({31'h0, xen}, 32'h0);
        slp <= 0;
        lfs <= 0;
        repeat (300) @(posedge clk);
        period(30);
        chk_near(span, 100, 2);
        for (int t = 0; t < 4; t++) sleep_tail(2'(t));
        wb(1, 8'h28, 32'h0);
        irq <= 1;
        slp <= 1;
        repeat (300) @(posedge clk);
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        repeat (100) @(posedge clk);
        chk_near(edges, 30, 2);
        irq <= 0;
        while (xen !== 1'b0) @(posedge clk);
        chk({31'h0, pin}, 32'h0);
        slp <= 0;
        wb(1, 8'h28, 32'h3F);
        rst_n <= 0;
        repeat (16) @(posedge clk);
        rst_n <= 1;
        wb(0, 8'h28, 0);
        chk(q, 32'h06);
        final_report;
    end
endmodule
